//--- sgo_pkg.sv
// Constants and types for the switchgear object control block
// Function
// R1: High open status input means the object is in the open position.
// R2: High close status input means the object is in the closed position.
// R3: High cart-in means racked in, high cart-out means pulled out.
// R4: High ready input means spring charged and close command acceptable.
// R5: High synchrocheck permission means closing conditions are met.
// R6: Open and close go out as separate pulses on separate outputs.
// R7: Both status inputs active beyond traverse time gives Bad status.
// R8: Neither status input active beyond traverse time gives Intermediate.
// R9: Close pulse ends at its maximum length or when closed is reached.
// R10: Open pulse ends at its maximum length or when open is reached.
// R11: No status change within termination timeout raises error, ends control.
// R12: Final trip signal lasts its set length; zero length means continuous.
// R13: Final trip only when no further auto-reclose is expected.
// R14: Panel control gated by two-bit access level, default configurator.
// R15: Local open and close requests come from selectable inputs.
// R16: Remote open and close requests come from selectable inputs.
// R17: Application open and close requests come from logical signals.
// R18: With synchrocheck in use, close only while permission is active.
// R19: Ready check high, low or unused; close only at selected level.
// R20: Blocking must arrive at least 5 ms before the command; the block has no blocking input.
// R21: Only open active gives Open, only closed gives Closed, per tick.
// R22: Never both commands at once; requests during a pulse are rejected.
package sgo_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS      = 5;
   localparam int STEP_MS     = 20;
   localparam int STEP_CYC    = STEP_MS * 1_000_000 / CLK_NS;
   localparam int STEP_W      = 16;
   localparam int TRAV_DEF_MS = 200;
   localparam int PULSE_DEF_MS = 200;
   localparam int TMO_DEF_MS  = 10_000;
   localparam int FTRIP_DEF_MS = 200;
   localparam int BLOCK_LEAD_MS = 5;
   localparam logic [STEP_W-1:0] TRAV_DEF = STEP_W'(TRAV_DEF_MS / STEP_MS);
   localparam logic [STEP_W-1:0] PULSE_DEF = STEP_W'(PULSE_DEF_MS / STEP_MS);
   localparam logic [STEP_W-1:0] TMO_DEF = STEP_W'(TMO_DEF_MS / STEP_MS);
   localparam logic [STEP_W-1:0] FTRIP_DEF = STEP_W'(FTRIP_DEF_MS / STEP_MS);
   // ---------------------------------------------------------------
   // Sources and access
   // ---------------------------------------------------------------
   localparam int SRC_LOCAL  = 0;
   localparam int SRC_REMOTE = 1;
   localparam int SRC_APP    = 2;
   localparam int SRC_N      = 3;
   localparam int PIN_N      = 10;
   localparam logic [1:0] ACC_DEF = 2'h2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      POS_MID    = 2'h0,
      POS_OPEN   = 2'h1,
      POS_CLOSED = 2'h2,
      POS_BAD    = 2'h3
   } sgo_pos_t;
   typedef enum logic [1:0] {
      RDY_HIGH  = 2'h0,
      RDY_LOW   = 2'h1,
      RDY_NONE  = 2'h2
   } sgo_rdy_t;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CLOSE = 2'h1,
      ST_WAIT  = 2'h3,
      ST_OPEN  = 2'h2
   } sgo_state_t;
endpackage : sgo_pkg

//--- sgo_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sgo_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sgo_sync
`default_nettype wire

//--- sgo_ctrl.sv
// Switchgear object control and position monitoring
`timescale 1ns/100ps
`default_nettype none
module sgo_ctrl #(
   parameter int TICK_CYCLES = sgo_pkg::STEP_CYC
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       open_status_in,
   input  wire logic       close_status_in,
   input  wire logic       cart_racked_in,
   input  wire logic       cart_racked_out,
   input  wire logic       ready_in,
   input  wire logic       sync_ok_in,
   input  wire logic       local_open_in,
   input  wire logic       local_close_in,
   input  wire logic       remote_open_in,
   input  wire logic       remote_close_in,
   input  wire logic       app_open,
   input  wire logic       app_close,
   input  wire logic       panel_open,
   input  wire logic       panel_close,
   input  wire logic [1:0] access_level,
   input  wire logic [1:0] access_req,
   input  wire logic [2:0] soft_signal_select,
   input  wire logic       withdrawable,
   input  wire logic       use_sync,
   input  wire logic [1:0] ready_mode,
   input  wire logic [15:0] traverse_steps,
   input  wire logic [15:0] close_pulse_steps,
   input  wire logic [15:0] open_pulse_steps,
   input  wire logic [15:0] timeout_steps,
   input  wire logic [15:0] ftrip_steps,
   input  wire logic       ar_reclose_pending,
   output logic            open_cmd,
   output logic            close_cmd,
   output logic      [1:0] obj_status,
   output logic      [1:0] wd_status,
   output logic            final_trip,
   output logic            ctrl_error,
   output logic            req_refused
);
   localparam int SW = sgo_pkg::STEP_W;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [sgo_pkg::PIN_N-1:0] pins;
   logic [sgo_pkg::PIN_N-1:0] pins_s;
   logic open_s;
   logic close_s;
   logic cin_s;
   logic cout_s;
   logic ready_s;
   logic sync_s;
   logic loc_open_s;
   logic loc_close_s;
   logic rem_open_s;
   logic rem_close_s;

   assign pins = {remote_close_in, remote_open_in, local_close_in,
                  local_open_in, sync_ok_in, ready_in, cart_racked_out,
                  cart_racked_in, close_status_in, open_status_in};

   sgo_sync #(
      .WIDTH (sgo_pkg::PIN_N)
   ) sgo_sync_i (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (pins),
      .q     (pins_s)
   );

   assign {rem_close_s, rem_open_s, loc_close_s, loc_open_s, sync_s,
           ready_s, cout_s, cin_s, close_s, open_s} = pins_s;

   // ---------------------------------------------------------------
   // Step tick
   // ---------------------------------------------------------------
   logic [31:0] tick_cnt_r;
   logic        tick;

   assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt_r <= 32'h0000_0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Position decode: object and cart
   // ---------------------------------------------------------------
   logic [1:0] pos_a;
   logic [1:0] pos_b;
   logic [1:0] pos_en;

   assign pos_a  = {cout_s, open_s};   // see R1 see R3
   assign pos_b  = {cin_s, close_s};   // see R2 see R3
   assign pos_en = {withdrawable, 1'b1};

   for (genvar g = 0; g < 2; g++) begin : gen_pos
      logic [1:0]    pos_r;
      logic [SW-1:0] trav_r;
      logic [SW-1:0] trav_cur;
      logic          last_r;

      assign trav_cur = (pos_a[g] == last_r) ? trav_r : '0;

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            pos_r  <= sgo_pkg::POS_MID;
            trav_r <= '0;
            last_r <= 1'b0;
         end else if (!pos_en[g]) begin
            pos_r  <= sgo_pkg::POS_MID;
            trav_r <= '0;
         end else if (tick) begin
            last_r <= pos_a[g];
            if (pos_a[g] ^ pos_b[g]) begin
               pos_r  <= pos_a[g] ? sgo_pkg::POS_OPEN
                                  : sgo_pkg::POS_CLOSED;   // see R21
               trav_r <= '0;
            end else if (trav_cur >= traverse_steps) begin
               pos_r  <= pos_a[g] ? sgo_pkg::POS_BAD
                                  : sgo_pkg::POS_MID;   // see R7 see R8
            end else begin
               trav_r <= trav_cur + SW'(1);
            end
         end
      end
   end

   assign obj_status = gen_pos[0].pos_r;
   assign wd_status  = gen_pos[1].pos_r;

   // ---------------------------------------------------------------
   // Request sources
   // ---------------------------------------------------------------
   logic panel_ok;
   logic open_lvl;
   logic close_lvl;
   logic open_lvl_r;
   logic close_lvl_r;
   logic open_req;
   logic close_req;
   logic ready_ok;
   logic close_ok;

   assign panel_ok = (access_level >= access_req);   // see R14

   assign open_lvl =
      (soft_signal_select[sgo_pkg::SRC_LOCAL] & loc_open_s)     // see R15
      | (soft_signal_select[sgo_pkg::SRC_REMOTE] & rem_open_s)  // see R16
      | (soft_signal_select[sgo_pkg::SRC_APP] & app_open)       // see R17
      | (panel_ok & panel_open);

   assign close_lvl =
      (soft_signal_select[sgo_pkg::SRC_LOCAL] & loc_close_s)    // see R15
      | (soft_signal_select[sgo_pkg::SRC_REMOTE] & rem_close_s) // see R16
      | (soft_signal_select[sgo_pkg::SRC_APP] & app_close)      // see R17
      | (panel_ok & panel_close);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         open_lvl_r  <= 1'b0;
         close_lvl_r <= 1'b0;
      end else begin
         open_lvl_r  <= open_lvl;
         close_lvl_r <= close_lvl;
      end
   end

   assign open_req  = open_lvl & ~open_lvl_r;
   assign close_req = close_lvl & ~close_lvl_r;

   always_comb begin
      case (ready_mode)
         sgo_pkg::RDY_HIGH: ready_ok = ready_s;    // see R4 see R19
         sgo_pkg::RDY_LOW:  ready_ok = ~ready_s;   // see R19
         default:           ready_ok = 1'b1;
      endcase
   end

   assign close_ok = ready_ok & (~use_sync | sync_s);   // see R5 see R18

   // ---------------------------------------------------------------
   // Control sequence
   // ---------------------------------------------------------------
   sgo_pkg::sgo_state_t state_r;
   sgo_pkg::sgo_state_t state_nxt;
   logic [SW-1:0]       cnt_r;
   logic                dir_open_r;
   logic                tmo_hit;
   logic                open_done;
   logic                busy;
   logic [SW-1:0]       cnt_inc;

   assign cnt_inc = cnt_r + SW'(1);
   assign tmo_hit = tick & (cnt_inc >= timeout_steps);   // see R11
   assign busy    = (state_r != sgo_pkg::ST_IDLE);
   assign open_done = busy & dir_open_r & (obj_status == sgo_pkg::POS_OPEN);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sgo_pkg::ST_IDLE: begin
            if (open_req) begin
               state_nxt = sgo_pkg::ST_OPEN;
            end else if (close_req && close_ok) begin
               state_nxt = sgo_pkg::ST_CLOSE;   // see R18 see R19
            end
         end
         sgo_pkg::ST_OPEN: begin
            if (obj_status == sgo_pkg::POS_OPEN || tmo_hit) begin
               state_nxt = sgo_pkg::ST_IDLE;   // see R10 see R11
            end else if (tick && cnt_inc >= open_pulse_steps) begin
               state_nxt = sgo_pkg::ST_WAIT;   // see R10
            end
         end
         sgo_pkg::ST_CLOSE: begin
            if (obj_status == sgo_pkg::POS_CLOSED || tmo_hit) begin
               state_nxt = sgo_pkg::ST_IDLE;   // see R9 see R11
            end else if (tick && cnt_inc >= close_pulse_steps) begin
               state_nxt = sgo_pkg::ST_WAIT;   // see R9
            end
         end
         sgo_pkg::ST_WAIT: begin
            if (tmo_hit) begin
               state_nxt = sgo_pkg::ST_IDLE;   // see R11
            end else if (obj_status == (dir_open_r ? sgo_pkg::POS_OPEN
                                                   : sgo_pkg::POS_CLOSED)) begin
               state_nxt = sgo_pkg::ST_IDLE;
            end
         end
         default: state_nxt = sgo_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sgo_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r      <= '0;
         dir_open_r <= 1'b0;
      end else if (!busy) begin
         cnt_r      <= '0;
         dir_open_r <= open_req;
      end else if (tick) begin
         cnt_r <= cnt_r + SW'(1);
      end
   end

   // ---------------------------------------------------------------
   // Command outputs and events
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         open_cmd  <= 1'b0;
         close_cmd <= 1'b0;
      end else begin
         open_cmd  <= (state_nxt == sgo_pkg::ST_OPEN);    // see R6 see R22
         close_cmd <= (state_nxt == sgo_pkg::ST_CLOSE);   // see R6 see R22
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_error  <= 1'b0;
         req_refused <= 1'b0;
      end else begin
         ctrl_error  <= busy & tmo_hit;   // see R11
         req_refused <= (busy & (open_req | close_req))      // see R22
                        | (~busy & ~open_req & close_req & ~close_ok);
      end
   end

   // ---------------------------------------------------------------
   // Final trip
   // ---------------------------------------------------------------
   logic [SW-1:0] ft_cnt_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         final_trip <= 1'b0;
         ft_cnt_r   <= '0;
      end else if (open_done && !ar_reclose_pending) begin
         final_trip <= 1'b1;   // see R12 see R13
         ft_cnt_r   <= '0;
      end else if (final_trip && state_nxt == sgo_pkg::ST_CLOSE) begin
         final_trip <= 1'b0;
      end else if (final_trip && ftrip_steps != '0 && tick) begin
         ft_cnt_r <= ft_cnt_r + SW'(1);
         if (ft_cnt_r + SW'(1) >= ftrip_steps) begin
            final_trip <= 1'b0;   // see R12
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n || !rst_n);

   cmd_exclusive_a: assert property ( // see R22
      !(open_cmd && close_cmd))
      else $error("open and close commands together");
   close_length_a: assert property ( // see R9
      close_cmd |-> cnt_r < close_pulse_steps)
      else $error("close pulse too long");
   open_stop_a: assert property ( // see R10
      open_cmd && obj_status == sgo_pkg::POS_OPEN |=> !open_cmd)
      else $error("open pulse kept after open reached");
   bad_status_a: assert property ( // see R7
      obj_status == sgo_pkg::POS_BAD
      && $past(obj_status) != sgo_pkg::POS_BAD
      |-> $past(open_s && close_s && tick))
      else $error("bad status without both inputs");
   mid_status_a: assert property ( // see R8
      obj_status == sgo_pkg::POS_MID
      && $past(obj_status) != sgo_pkg::POS_MID
      |-> $past(!open_s && !close_s && tick))
      else $error("intermediate without idle inputs");
   open_status_a: assert property ( // see R21
      obj_status == sgo_pkg::POS_OPEN
      && $past(obj_status) != sgo_pkg::POS_OPEN
      |-> $past(open_s && !close_s))
      else $error("open status without open input");
   sync_gate_a: assert property ( // see R18
      $rose(close_cmd) |-> $past(!use_sync || sync_s))
      else $error("close without synchrocheck");
   ready_gate_a: assert property ( // see R19
      $rose(close_cmd) |-> $past(ready_mode[1]
                                 || ready_s == (ready_mode == sgo_pkg::RDY_HIGH)))
      else $error("close without ready");
   timeout_end_a: assert property ( // see R11
      ctrl_error |-> !open_cmd && !close_cmd ##1 !ctrl_error)
      else $error("control not ended on timeout");
   ftrip_start_a: assert property ( // see R13
      $rose(final_trip) |-> $past(!ar_reclose_pending)
                            && obj_status == sgo_pkg::POS_OPEN)
      else $error("final trip while reclose expected");
endmodule : sgo_ctrl
`default_nettype wire

//--- sgo_brk_model.sv
// Breaker contact model answering the relay commands
`timescale 1ns/100ps
`default_nettype none
module sgo_brk_model #(
   parameter int DLY = 4
) (
   input  wire logic       mclk,
   input  wire logic       open_cmd,
   input  wire logic       close_cmd,
   input  wire logic [1:0] mode,
   output var logic        open_st,
   output var logic        close_st
);
   // ----------------------------------------
   // Mechanism: 0 moves, 1 stuck, 2 both, 3 none
   // ----------------------------------------
   logic pos_r = 1'b0;
   int   cnt_r = 0;
   always @(posedge mclk) begin
      if (mode == 2'h0 && ((close_cmd && !pos_r) || (open_cmd && pos_r))) begin
         cnt_r <= cnt_r + 1;
         if (cnt_r == DLY) begin
            pos_r <= ~pos_r;
            cnt_r <= 0;
         end
      end else begin
         cnt_r <= 0;
      end
   end
   assign open_st  = (mode == 2'h2) | ((mode < 2'h2) & ~pos_r);
   assign close_st = (mode == 2'h2) | ((mode < 2'h2) & pos_r);
endmodule : sgo_brk_model
`default_nettype wire

//--- tb_switchgear_object_control.sv
// Testbench for the switchgear object control block
`timescale 1ns/100ps
`default_nettype none
module tb_switchgear_object_control;
   localparam int TK = 8;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        opn_st, cls_st, cart_in = 1'b0, cart_out = 1'b0;
   logic        rdy = 1'b0, sync_ok = 1'b0, wd = 1'b0, use_sync = 1'b0, ar = 1'b0;
   logic [7:0]  rq = 8'h00;
   logic [1:0]  acc_lvl = 2'h3, acc_req = 2'h2, rdy_mode = 2'h2, mode = 2'h0;
   logic [2:0]  sel = 3'h7;
   logic [15:0] ftrip = 16'h0003;
   logic        open_cmd, close_cmd, final_trip, ctrl_error, req_refused, h, r;
   logic [1:0]  obj_status, wd_status;
   int          fail_count = 0, num_checks = 0, cyc = 0, n, m;
   // ----------------------------------------
   // Instances
   // ----------------------------------------
   sgo_ctrl #(.TICK_CYCLES(TK)) sgo_ctrl_i (
      .mclk(mclk), .reset_n(reset_n), .open_status_in(opn_st), .close_status_in(cls_st),
      .cart_racked_in(cart_in), .cart_racked_out(cart_out), .ready_in(rdy),
      .sync_ok_in(sync_ok), .local_open_in(rq[0]), .local_close_in(rq[1]),
      .remote_open_in(rq[2]), .remote_close_in(rq[3]), .app_open(rq[4]), .app_close(rq[5]),
      .panel_open(rq[6]), .panel_close(rq[7]), .access_level(acc_lvl), .access_req(acc_req),
      .soft_signal_select(sel), .withdrawable(wd), .use_sync(use_sync), .ready_mode(rdy_mode),
      .traverse_steps(16'h0003), .close_pulse_steps(16'h0004), .open_pulse_steps(16'h0004),
      .timeout_steps(16'h000a), .ftrip_steps(ftrip), .ar_reclose_pending(ar),
      .open_cmd(open_cmd), .close_cmd(close_cmd), .obj_status(obj_status),
      .wd_status(wd_status), .final_trip(final_trip), .ctrl_error(ctrl_error),
      .req_refused(req_refused));
   sgo_brk_model sgo_brk_model_i (
      .mclk(mclk), .open_cmd(open_cmd), .close_cmd(close_cmd), .mode(mode),
      .open_st(opn_st), .close_st(cls_st));
   // ----------------------------------------
   // Clock, watchdog, helpers
   // ----------------------------------------
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   always @(negedge mclk) begin
      if (open_cmd === 1'b1) chk(close_cmd, 1'b0);
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rng(input int v, input int lo, input int hi);
      num_checks++;
      if (v < lo || v > hi) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, v, lo);
      end
   endtask : rng
   task automatic cyc_n(input int k);
      repeat (k) @(negedge mclk);
   endtask : cyc_n
   function automatic logic outp(input int w);
      case (w)
         0: return open_cmd;
         1: return close_cmd;
         2: return final_trip;
         default: return ctrl_error;
      endcase
   endfunction : outp
   task automatic wl(input int w, input logic lv, input int lim, output int k);
      k = 0;
      while (outp(w) === lv && k < lim) begin
         @(negedge mclk);
         k++;
      end
   endtask : wl
   task automatic wst(input logic [1:0] e, input int lim);
      int k;
      k = 0;
      while (obj_status !== e && k < lim) begin
         @(negedge mclk);
         k++;
      end
      chk(obj_status, e);
   endtask : wst
   task automatic go(input int s, output logic hit, output logic rf);
      cyc_n(3); // Conditions settle before the request
      hit = 1'b0;
      rf = 1'b0;
      rq[s] = 1'b1;
      repeat (6) begin
         @(negedge mclk);
         hit |= (outp(s % 2) === 1'b1);
         rf |= (req_refused === 1'b1);
      end
      rq = 8'h00;
      cyc_n(1);
   endtask : go
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_status;
      wst(2'h1, 40);
      mode = 2'h2;
      cyc_n(2 + TK);
      chk(obj_status, 2'h1);
      wst(2'h3, 6 * TK);
      mode = 2'h3;
      cyc_n(2 + TK);
      chk(obj_status, 2'h3);
      wst(2'h0, 6 * TK);
      mode = 2'h0;
      wst(2'h1, 2 * TK);
   endtask : t_status
   task automatic t_wd;
      wd = 1'b1;
      cart_in = 1'b1;
      cyc_n(2 * TK + 4);
      chk(wd_status, 2'h2);
      cart_in = 1'b0;
      cart_out = 1'b1;
      cyc_n(2 * TK + 4);
      chk(wd_status, 2'h1);
      wd = 1'b0;
      cyc_n(2 * TK + 4);
      chk(wd_status, 2'h0);
   endtask : t_wd
   task automatic t_close;
      go(5, h, r);
      chk(h, 1'b1);
      wl(1, 1'b1, 40, n);
      rng(n, 1, 16);
      wst(2'h2, 4);
   endtask : t_close
   task automatic t_open_ar;
      ar = 1'b1;
      sel = 3'h6;
      go(0, h, r);
      chk(h, 1'b0);
      cyc_n(2);
      sel = 3'h7;
      go(0, h, r);
      chk(h, 1'b1);
      wl(0, 1'b1, 40, n);
      rng(n, 1, 16);
      wst(2'h1, 4);
      cyc_n(3 * TK);
      chk(final_trip, 1'b0);
      ar = 1'b0;
   endtask : t_open_ar
   task automatic t_refuse;
      use_sync = 1'b1;
      go(3, h, r);
      chk({h, r}, 2'b01);
      sync_ok = 1'b1;
      rdy_mode = 2'h0;
      go(3, h, r);
      chk({h, r}, 2'b01);
      rdy_mode = 2'h1;
      rdy = 1'b1;
      go(3, h, r);
      chk({h, r}, 2'b01);
      rdy_mode = 2'h0;
      go(3, h, r);
      chk({h, r}, 2'b10);
      wl(1, 1'b1, 40, n);
      wst(2'h2, 4);
      use_sync = 1'b0;
      rdy_mode = 2'h2;
   endtask : t_refuse
   task automatic t_ftrip;
      go(4, h, r);
      wl(2, 1'b0, 40, n);
      chk(final_trip, 1'b1);
      wl(2, 1'b1, 40, n);
      rng(n, 2 * TK - 1, 3 * TK + 2);
      wst(2'h1, 4);
   endtask : t_ftrip
   task automatic t_panel;
      acc_lvl = 2'h1;
      go(7, h, r);
      chk({h, r}, 2'b00);
      acc_lvl = 2'h2;
      go(7, h, r);
      chk(h, 1'b1);
      wl(1, 1'b1, 40, n);
      wst(2'h2, 4);
   endtask : t_panel
   task automatic t_ftc;
      ftrip = 16'h0000;
      go(4, h, r);
      wl(2, 1'b0, 40, n);
      cyc_n(8 * TK);
      chk(final_trip, 1'b1);
      go(5, h, r);
      chk(final_trip, 1'b0);
      wl(1, 1'b1, 40, n);
      wst(2'h2, 4);
      ftrip = 16'h0003;
   endtask : t_ftc
   task automatic t_tmo;
      mode = 2'h1;
      go(2, h, r);
      chk(h, 1'b1);
      go(5, h, r);
      chk({h, r}, 2'b01);
      wl(0, 1'b1, 60, n);
      rng(n + 14, 3 * TK - 2, 4 * TK + 3);
      wl(3, 1'b0, 12 * TK, m);
      rng(n + 14 + m, 9 * TK - 2, 10 * TK + 3);
      cyc_n(1);
      chk({ctrl_error, open_cmd}, 2'b00);
      mode = 2'h0;
   endtask : t_tmo
   initial begin
      cyc_n(20);
      reset_n = 1'b1;
      cyc_n(6);
      t_status();
      t_wd();
      t_close();
      t_open_ar();
      t_refuse();
      t_ftrip();
      t_panel();
      t_ftc();
      t_tmo();
      end_of_test();
   end
endmodule : tb_switchgear_object_control
`default_nettype wire
